/* smartcard_status_pkg.sv */
package smartcard_status_pkg;

  // Register addresses on the plain register port.
  localparam logic [1:0] STATUS_ADDR = 2'h0;
  localparam logic [1:0] CONTROL_ADDR = 2'h1;

  // Status register bit positions.
  localparam int MP_TX_BIT = 0;
  localparam int MP_RX_BIT = 1;
  localparam int TX_END_BIT = 2;
  localparam int PARITY_BIT = 3;
  localparam int ERR_SIG_BIT = 4;
  localparam int OVERRUN_BIT = 5;
  localparam int RX_FULL_BIT = 6;
  localparam int TX_EMPTY_BIT = 7;

  // Lowest and highest status bits that are write-0-to-clear flags.
  localparam int FLAG_LO = 2;
  localparam int FLAG_HI = 7;

  // Control register bit positions.
  localparam int CTL_TX_EN_BIT = 0;
  localparam int CTL_EARLY_BIT = 1;
  localparam int CTL_BLOCK_BIT = 2;
  localparam int CTL_CARD_BIT = 3;

  // Reset values: transmit-empty and transmit-end start at one.
  localparam logic [7:0] STATUS_RESET = 8'h84;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] CONTROL_MASK = 8'h0F;

  // Transmit-end delays in half bit periods: 2.5, 1.5 and 1.0 etu.
  localparam logic [2:0] HALF_ETU_NORMAL = 3'h5;
  localparam logic [2:0] HALF_ETU_BLOCK = 3'h3;
  localparam logic [2:0] HALF_ETU_EARLY = 3'h2;

  // Early-end mode dominates block mode when choosing the delay.
  function automatic logic [2:0] end_delay(input logic early, input logic block);
    if (early) begin
      return HALF_ETU_EARLY;
    end else if (block) begin
      return HALF_ETU_BLOCK;
    end
    return HALF_ETU_NORMAL;
  endfunction : end_delay

endpackage : smartcard_status_pkg

/* etu_delay.sv */
`timescale 1ns/1ps
`default_nettype none
module etu_delay
  import smartcard_status_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Control.
  input wire logic start,
  input wire logic cancel,
  input wire logic half_tick,
  input wire logic [2:0] target,
  // Result.
  output logic done
);

  logic busy_reg;
  logic [2:0] count_reg;
  logic [2:0] target_reg;
  logic [2:0] count_next;

  assign count_next = count_reg + 3'h1;

  // Busy window: a new start restarts the count, cancel abandons it.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_reg <= 1'b0;
    end else if (cancel) begin
      busy_reg <= 1'b0;
    end else if (start) begin
      busy_reg <= 1'b1;
    end else if (busy_reg && half_tick && count_next == target_reg) begin
      busy_reg <= 1'b0;
    end
  end

  // Half bit periods counted since the end of the character.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= 3'h0;
      target_reg <= HALF_ETU_NORMAL;
    end else if (start) begin
      count_reg <= 3'h0;
      target_reg <= target;
    end else if (busy_reg && half_tick) begin
      count_reg <= count_next;
    end
  end

  // The done pulse is registered so the flag logic sees a clean one-cycle event.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      done <= 1'b0;
    end else begin
      done <= busy_reg && half_tick && !start && !cancel && count_next == target_reg;
    end
  end

  // The counter never passes the chosen delay.
  chk_count_bounded: assert property (@(posedge clk) disable iff (!rst_n)
    busy_reg |-> count_reg < target_reg)
    else $error("etu counter passed its target");

  // Done only follows a busy cycle with a tick.
  chk_done_cause: assert property (@(posedge clk) disable iff (!rst_n)
    done |-> $past(busy_reg) && $past(half_tick))
    else $error("etu done without a running count");

  cov_delay_done: cover property (@(posedge clk) disable iff (!rst_n) done);

endmodule : etu_delay
`default_nettype wire

/* smartcard_status_flags.sv */
// Function
// - Overrun flag, bit 5, sets when a character completes while receive-full is one.
// - Error and end flags clear on writing 0 after reading 1; writing 1 ignored.
// - Error-signal flag, bit 4, sets on sampled low error signal; resets to 0.
// - Parity error flag, bit 3, sets on parity mismatch during reception; resets 0.
// - Transmit-end, bit 2, clears on writing 0 after reading 1, resets 1, set while transmit disabled and no error.
// - After a byte, transmit-end sets after delay if no error and transmit-empty.
// - Delay is 2.5 etu normally, 1.5 with block mode, 1.0 with early-end.
// - DMA or transfer-controller write to transmit data clears transmit-end.
// - Received multiprocessor bit, bit 1, unused, read-only, reads 0.
// - Smart card flag behaviour applies only when mode select is one.
// - Receive-full sets when a reception ends normally and data moves to receive register.
// - Transmit-empty sets on transfer to shift register or while transmit disabled.
`timescale 1ns/1ps
`default_nettype none
module smartcard_status_flags
  import smartcard_status_pkg::*;
(
  // Clock and reset.
  input wire logic MCLK,
  input wire logic RESET_N,
  // Register port.
  input wire logic [1:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  // Receiver events.
  input wire logic RX_DONE,
  input wire logic RX_PARITY_BAD,
  input wire logic ERR_SIGNAL_LOW,
  // Transmitter events.
  input wire logic TX_LOAD,
  input wire logic TX_CHAR_END,
  input wire logic HALF_ETU_TICK,
  input wire logic DMA_TDR_WRITE,
  // Flags and controls toward the datapath.
  output logic TX_EMPTY,
  output logic RX_FULL,
  output logic TRANSMIT_END,
  output logic TRANSMIT_ENABLE,
  output logic SMARTCARD_MODE
);

  logic [7:0] status_reg;
  logic [7:0] status_next;
  logic [FLAG_HI:FLAG_LO] armed_reg;
  logic [7:0] control_reg;
  logic [7:0] set_vec;
  logic [7:0] clr_vec;
  logic status_wr;
  logic status_rd;
  logic tx_enable;
  logic card_mode;
  logic delay_done;
  logic overrun_seen_reg;

  assign status_wr = WR && ADDR == STATUS_ADDR;
  assign status_rd = RD && ADDR == STATUS_ADDR;
  assign tx_enable = control_reg[CTL_TX_EN_BIT];
  assign card_mode = control_reg[CTL_CARD_BIT];

  // Control register steers transmit enable, the delay modes and the mode select.
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      control_reg <= CONTROL_RESET;
    end else if (WR && ADDR == CONTROL_ADDR) begin
      control_reg <= WDATA & CONTROL_MASK;
    end
  end

  // Transmit-end delay runs in half bit periods so 2.5 etu needs no fraction.
  etu_delay end_timer (
    .clk(MCLK),
    .rst_n(RESET_N),
    .start(TX_CHAR_END && card_mode),
    .cancel(!tx_enable),
    .half_tick(HALF_ETU_TICK),
    .target(end_delay(control_reg[CTL_EARLY_BIT], control_reg[CTL_BLOCK_BIT])),
    .done(delay_done)
  );

  // Hardware set conditions for each flag.
  always_comb begin
    set_vec = 8'h00;
    set_vec[OVERRUN_BIT] = RX_DONE && status_reg[RX_FULL_BIT];
    set_vec[PARITY_BIT] = RX_DONE && RX_PARITY_BAD;
    set_vec[ERR_SIG_BIT] = ERR_SIGNAL_LOW && card_mode;
    set_vec[RX_FULL_BIT] = RX_DONE && !RX_PARITY_BAD && !status_reg[RX_FULL_BIT];
    set_vec[TX_EMPTY_BIT] = TX_LOAD || !tx_enable;
    if (card_mode) begin
      set_vec[TX_END_BIT] = !status_reg[ERR_SIG_BIT]
        && ((!tx_enable) || (delay_done && status_reg[TX_EMPTY_BIT]));
    end else begin
      set_vec[TX_END_BIT] = !tx_enable || (TX_CHAR_END && status_reg[TX_EMPTY_BIT]);
    end
  end

  // Clears: software zero after a one was read, plus the transfer-controller write.
  always_comb begin
    clr_vec = 8'h00;
    for (int i = FLAG_LO; i <= FLAG_HI; i++) begin
      clr_vec[i] = status_wr && armed_reg[i] && !WDATA[i];
    end
    clr_vec[TX_END_BIT] = clr_vec[TX_END_BIT] || DMA_TDR_WRITE;
    clr_vec[TX_EMPTY_BIT] = clr_vec[TX_EMPTY_BIT] || DMA_TDR_WRITE;
  end

  // A set in the same cycle as a clear wins so no event is lost.
  always_comb begin
    status_next = status_reg;
    for (int i = FLAG_LO; i <= FLAG_HI; i++) begin
      status_next[i] = set_vec[i] || (status_reg[i] && !clr_vec[i]);
    end
    status_next[MP_RX_BIT] = 1'b0;
    if (status_wr) begin
      status_next[MP_TX_BIT] = WDATA[MP_TX_BIT];
    end
  end

  // The status register takes the merged next value on every edge.
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      status_reg <= STATUS_RESET;
    end else begin
      status_reg <= status_next;
    end
  end

  // Remember which flags software has seen at one; a write consumes the memory.
  generate
    for (genvar g = FLAG_LO; g <= FLAG_HI; g++) begin : g_arm
      always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
          armed_reg[g] <= 1'b0;
        end else if (status_wr) begin
          armed_reg[g] <= 1'b0;
        end else if (status_rd && status_reg[g]) begin
          armed_reg[g] <= 1'b1;
        end else if (!status_reg[g]) begin
          armed_reg[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // Read data stands only in the cycle after the read strobe; unmapped reads give zero.
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      RDATA <= 8'h00;
    end else if (status_rd) begin
      RDATA <= status_reg;
    end else if (RD && ADDR == CONTROL_ADDR) begin
      RDATA <= control_reg;
    end else begin
      RDATA <= 8'h00;
    end
  end

  assign TX_EMPTY = status_reg[TX_EMPTY_BIT];
  assign RX_FULL = status_reg[RX_FULL_BIT];
  assign TRANSMIT_END = status_reg[TX_END_BIT];
  assign TRANSMIT_ENABLE = tx_enable;
  assign SMARTCARD_MODE = card_mode;

  // Checker memory of the overrun flag read as one since the last status write.
  // It is kept apart from the arming logic so the clear check does not trust it.
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      overrun_seen_reg <= 1'b0;
    end else if (status_wr) begin
      overrun_seen_reg <= 1'b0;
    end else if (status_rd && status_reg[OVERRUN_BIT]) begin
      overrun_seen_reg <= 1'b1;
    end
  end

  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RESET_N);

  chk_overrun_set: assert property (
    RX_DONE && status_reg[RX_FULL_BIT] |=> status_reg[OVERRUN_BIT])
    else $error("overrun flag not set");

  chk_write_one_keeps: assert property (
    status_wr && WDATA[PARITY_BIT] && status_reg[PARITY_BIT] |=> status_reg[PARITY_BIT])
    else $error("writing one changed parity flag");

  chk_clear_needs_read: assert property (
    status_wr && !overrun_seen_reg && status_reg[OVERRUN_BIT] |=> status_reg[OVERRUN_BIT])
    else $error("overrun cleared without prior read");

  chk_error_signal_set: assert property (
    ERR_SIGNAL_LOW && card_mode |=> status_reg[ERR_SIG_BIT])
    else $error("error signal flag not set");

  chk_parity_set: assert property (
    RX_DONE && RX_PARITY_BAD |=> status_reg[PARITY_BIT])
    else $error("parity flag not set");

  chk_end_idle: assert property (
    !tx_enable && !status_reg[ERR_SIG_BIT] && !DMA_TDR_WRITE |=> status_reg[TX_END_BIT])
    else $error("transmit end low while transmitter disabled");

  chk_end_delay: assert property (
    delay_done && !status_reg[ERR_SIG_BIT] && status_reg[TX_EMPTY_BIT] && card_mode
    |=> status_reg[TX_END_BIT])
    else $error("transmit end missing after delay");

  chk_end_early: assert property (
    TX_CHAR_END && card_mode && tx_enable && control_reg[CTL_EARLY_BIT] && !WR
    ##1 !HALF_ETU_TICK[*1] |=> !delay_done)
    else $error("transmit end delay too short");

  chk_dma_clear: assert property (
    DMA_TDR_WRITE && tx_enable |=> !status_reg[TX_END_BIT] || $past(set_vec[TX_END_BIT]))
    else $error("transfer write did not clear transmit end");

  chk_unused_bit_zero: assert property (status_reg[MP_RX_BIT] == 1'b0)
    else $error("unused multiprocessor bit set");

  chk_read_timing: assert property (
    status_rd |=> RDATA == $past(status_reg))
    else $error("status read data wrong");

  cov_overrun: cover property (set_vec[OVERRUN_BIT]);
  cov_end_timed: cover property (delay_done && status_reg[TX_EMPTY_BIT]);
  cov_sw_clear: cover property (status_rd ##1 status_wr && clr_vec[PARITY_BIT]);
  cov_dma_write: cover property (DMA_TDR_WRITE && status_reg[TX_END_BIT]);

endmodule : smartcard_status_flags
`default_nettype wire

/* smartcard_card_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Card side of the link: it finishes characters and pulls the error signal low.
module smartcard_card_model (
  // Clock.
  input wire logic clk,
  // Events toward the status logic.
  output logic rx_done,
  output logic parity_bad,
  output logic err_low
);
  // Quiet lines at time zero.
  initial begin
    rx_done = 1'b0;
    parity_bad = 1'b0;
    err_low = 1'b0;
  end
  // The qualifier flips after the pulse, so an idle value is never trusted.
  task automatic send_char(input logic bad);
    @(posedge clk);
    rx_done <= 1'b1;
    parity_bad <= bad;
    @(posedge clk);
    rx_done <= 1'b0;
    parity_bad <= ~bad;
  endtask : send_char
  // One sampled low level of the error signal.
  task automatic reject();
    @(posedge clk);
    err_low <= 1'b1;
    @(posedge clk);
    err_low <= 1'b0;
  endtask : reject
endmodule : smartcard_card_model
`default_nettype wire

/* smartcard_serial_status_flags_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
  $display("ERROR %0t: got %h expected %h", $time, g, e); end end
module smartcard_serial_status_flags_bench;
  import smartcard_status_pkg::*;
  logic MCLK = 1'b0;
  logic RESET_N = 1'b0;
  logic [1:0] ADDR = 2'h0;
  logic [7:0] WDATA = 8'h00;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic [3:0] ev = 4'h0;
  logic [7:0] RDATA;
  logic rx_done, parity_bad, err_low;
  logic TX_EMPTY, RX_FULL, TRANSMIT_END, TRANSMIT_ENABLE, SMARTCARD_MODE;
  logic tx_empty_exp, rx_full_exp, overrun_exp, err_sig_exp, parity_exp, tx_end_exp;
  logic early_mode, block_mode, bad, err;
  int tests_run = 0;
  int n_mismatch = 0;
  int cycles = 0;
  int r, k, n, m;

  smartcard_card_model i_card (.clk(MCLK), .rx_done(rx_done), .parity_bad(parity_bad),
    .err_low(err_low));
  smartcard_status_flags i_dut (.MCLK(MCLK), .RESET_N(RESET_N), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .RX_DONE(rx_done), .RX_PARITY_BAD(parity_bad),
    .ERR_SIGNAL_LOW(err_low), .TX_LOAD(ev[0]), .TX_CHAR_END(ev[1]), .HALF_ETU_TICK(ev[2]),
    .DMA_TDR_WRITE(ev[3]), .TX_EMPTY(TX_EMPTY), .RX_FULL(RX_FULL),
    .TRANSMIT_END(TRANSMIT_END), .TRANSMIT_ENABLE(TRANSMIT_ENABLE),
    .SMARTCARD_MODE(SMARTCARD_MODE));

  // Free-running 200 MHz clock.
  always #2.5 MCLK = ~MCLK;

  // A hang is cut short long after the few hundred cycles the run needs.
  always @(posedge MCLK) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  function automatic logic [7:0] status_of();
    return {tx_empty_exp, rx_full_exp, overrun_exp, err_sig_exp, parity_exp, tx_end_exp,
      2'h0};
  endfunction : status_of
  function automatic int half_etus(input logic g, input logic b);
    return g ? 2 : (b ? 3 : 5);
  endfunction : half_etus

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge MCLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge MCLK);
    WR <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe.
  task automatic rd(input logic [1:0] a, input logic [7:0] e, input logic [7:0] mk);
    @(posedge MCLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge MCLK);
    RD <= 1'b0;
    #1 `CHK(RDATA & mk, e & mk)
  endtask : rd
  task automatic pulse(input int i);
    @(posedge MCLK);
    ev[i] <= 1'b1;
    @(posedge MCLK);
    ev[i] <= 1'b0;
  endtask : pulse

  // Main sequence: reset, normal mode, receive flags, then transmit-end timing.
  initial begin
    void'($urandom(32'h13BC));
    {tx_empty_exp, rx_full_exp, overrun_exp, err_sig_exp, parity_exp, tx_end_exp} = 6'h21;
    repeat (6) @(posedge MCLK);
    RESET_N <= 1'b1;
    rd(STATUS_ADDR, status_of(), 8'hFF);
    rd(2'h2, 8'h00, 8'hFF);
    i_card.reject();
    rd(STATUS_ADDR, status_of(), 8'hFF);
    wr(CONTROL_ADDR, 8'h08);
    for (r = 0; r < 6; r++) begin
      n = $urandom_range(1, 3);
      for (k = 0; k < n; k++) begin
        bad = rx_full_exp ? 1'b0 : 1'($urandom_range(0, 1));
        if (rx_full_exp) overrun_exp = 1'b1;
        if (bad) parity_exp = 1'b1;
        else rx_full_exp = 1'b1;
        i_card.send_char(bad);
      end
      if (r == 0 || $urandom_range(0, 1) == 1) begin
        err_sig_exp = 1'b1;
        i_card.reject();
      end
      @(posedge MCLK);
      #1 `CHK(RX_FULL, rx_full_exp)
      wr(STATUS_ADDR, 8'hFE);
      wr(STATUS_ADDR, 8'h00);
      rd(STATUS_ADDR, status_of(), 8'hFB);
      wr(STATUS_ADDR, 8'h00);
      {rx_full_exp, overrun_exp, err_sig_exp, parity_exp} = 4'h0;
      repeat (2) @(posedge MCLK);
      rd(STATUS_ADDR, status_of(), 8'hFF);
    end
    for (m = 0; m < 4; m++) begin
      {early_mode, block_mode} = 2'(m);
      err = 1'($urandom_range(0, 1));
      wr(CONTROL_ADDR, {4'h0, 1'b1, block_mode, early_mode, 1'b1});
      pulse(3);
      #1 `CHK({SMARTCARD_MODE, TRANSMIT_ENABLE, TX_EMPTY, TRANSMIT_END}, 4'hC)
      pulse(0);
      #1 `CHK(TX_EMPTY, 1'b1)
      pulse(1);
      if (err) i_card.reject();
      n = half_etus(early_mode, block_mode);
      for (k = 0; k < n; k++) begin
        repeat (2) @(posedge MCLK);
        #1 `CHK(TRANSMIT_END, 1'b0)
        pulse(2);
      end
      repeat (2) @(posedge MCLK);
      #1 `CHK(TRANSMIT_END, !err)
      rd(STATUS_ADDR, {3'h0, err, 4'h0}, 8'h10);
      wr(STATUS_ADDR, 8'h00);
      wr(CONTROL_ADDR, 8'h08);
      repeat (2) @(posedge MCLK);
      rd(STATUS_ADDR, 8'h84, 8'hFF);
    end
    // Normal mode: transmit end follows the character end with no timer.
    wr(CONTROL_ADDR, 8'h01);
    pulse(3);
    #1 `CHK({TX_EMPTY, TRANSMIT_END}, 2'h0)
    pulse(0);
    pulse(1);
    #1 `CHK(TRANSMIT_END, 1'b1)
    // A transfer write while the transmitter is off loses to the set condition.
    wr(CONTROL_ADDR, 8'h08);
    pulse(3);
    #1 `CHK({TX_EMPTY, TRANSMIT_END}, 2'h3)
    // A second reset in mid-run must restore every reset value.
    wr(CONTROL_ADDR, 8'h0F);
    @(posedge MCLK);
    RESET_N <= 1'b0;
    repeat (2) @(posedge MCLK);
    RESET_N <= 1'b1;
    #1 `CHK({SMARTCARD_MODE, TRANSMIT_ENABLE, TX_EMPTY, RX_FULL, TRANSMIT_END}, 5'h05)
    rd(CONTROL_ADDR, 8'h00, 8'hFF);
    rd(STATUS_ADDR, 8'h84, 8'hFF);
    report_and_stop();
  end
endmodule : smartcard_serial_status_flags_bench
`default_nettype wire
